// *** inc/pmc_pkg.sv ***
// constants and types shared by the clock-mode controller of the pdm microphone
package pmc_pkg;

  // system clock rate
  localparam int PMC_CLK_KHZ = 100000;

  // clock frequencies that pick the operating mode
  localparam int PMC_LP_KHZ = 768;
  localparam int PMC_LP_BOUND_KHZ = 1200;
  localparam int PMC_SLEEP_KHZ = 200;

  // latencies
  localparam int PMC_SLEEP_ENTRY_MS = 10;
  localparam int PMC_WAKE_MS = 10;
  localparam int PMC_START_MS = 20;

  // derived cycle counts
  localparam int PMC_SLEEP_PER_CYC = PMC_CLK_KHZ / PMC_SLEEP_KHZ;
  localparam int PMC_LP_NOM_CYC = PMC_CLK_KHZ / PMC_LP_KHZ;
  localparam int PMC_LP_MIN_CYC = PMC_CLK_KHZ / PMC_LP_BOUND_KHZ;
  localparam int PMC_SLEEP_ENTRY_CYC = PMC_SLEEP_ENTRY_MS * PMC_CLK_KHZ;
  localparam int PMC_WAKE_CYC = PMC_WAKE_MS * PMC_CLK_KHZ;
  localparam int PMC_START_CYC = PMC_START_MS * PMC_CLK_KHZ;

  // widths and sizes
  localparam int PMC_PER_W = 10;
  localparam int PMC_CNT_W = 21;
  localparam int PMC_FIFO_W = 1;
  localparam int PMC_FIFO_DEPTH = 32;

  // reset values
  localparam logic PMC_SEL_RST = 1'b0;
  localparam logic PMC_DATA_RST = 1'b0;

  typedef enum logic [1:0] {
    PMC_ST_START = 2'b00,
    PMC_ST_SLEEP = 2'b01,
    PMC_ST_WAKE = 2'b10,
    PMC_ST_RUN = 2'b11
  } pmc_state_e;

endpackage : pmc_pkg

// *** rtl/pmc_fifo.sv ***
// bit-stream fifo between the modulator and the data pin driver
`timescale 1ns/1ns
module pmc_fifo import pmc_pkg::*; #(
  parameter int W = PMC_FIFO_W,
  parameter int DEPTH = PMC_FIFO_DEPTH
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low active
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // read request
  output logic [W-1:0] out_data // head word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } pmc_fifo_s;

  pmc_fifo_s s_q;
  pmc_fifo_s s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.cnt == (AW+1)'(DEPTH)) && !pop |=> !in_ready && (s_q.cnt == (AW+1)'(DEPTH)))
    else $error("fifo overfilled or lost its fill level");

endmodule : pmc_fifo

// *** rtl/pmc_clk_mon.sv ***
// measures the period of the incoming pdm clock and flags a slow or stopped clock
`timescale 1ns/1ns
module pmc_clk_mon import pmc_pkg::*; #(
  parameter int SLEEP_PER = PMC_SLEEP_PER_CYC
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low active
  input wire logic pdm_clk, // microphone clock, sampled
  output logic rise, // rising edge seen, pulse
  output logic fall, // falling edge seen, pulse
  output logic slow, // clock below sleep threshold, level
  output logic [PMC_PER_W-1:0] period // last period in cycles
);

  typedef struct packed {
    logic prev;
    logic [PMC_PER_W-1:0] cnt;
    logic [PMC_PER_W-1:0] per;
    logic slow;
  } pmc_mon_s;

  pmc_mon_s s_q;
  pmc_mon_s s_d;

  assign rise = pdm_clk & ~s_q.prev;
  assign fall = ~pdm_clk & s_q.prev;
  assign slow = s_q.slow;
  assign period = s_q.per;

  always_comb begin
    s_d = s_q;
    s_d.prev = pdm_clk;
    if (rise) begin
      s_d.per = s_q.cnt + 1'b1;
      s_d.cnt = '0;
      s_d.slow = 1'b0;
    end else if (s_q.cnt != PMC_PER_W'(SLEEP_PER - 1)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else begin
      // no rising edge for a whole sleep-threshold period
      s_d.slow = 1'b1;
      s_d.per = PMC_PER_W'(SLEEP_PER);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '{prev: 1'b0, cnt: '0, per: '0, slow: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  AST_SLOW_DETECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.cnt == PMC_PER_W'(SLEEP_PER - 1)) && !rise |=> slow)
    else $error("stopped clock not flagged slow");

  AST_SLOW_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rise |=> !slow && (s_q.cnt == '0))
    else $error("clock edge did not clear slow flag");

endmodule : pmc_clk_mon

// *** rtl/pmc_top.sv ***
// pdm microphone mode controller: picks mode from the clock rate and drives the shared data line
//
// Notes on behaviour
// - a clock at the low-power rate selects low-power listening with valid output.
// - a clock below the sleep threshold puts the device asleep with data tristated; during start-up the code stays in start-up instead, data tristated.
// - sleep is entered within the sleep latency after the clock slows.
// - after the clock returns, settled data appears within the wake-up latency.
// - after power and clock, settled data appears within the start-up time.
// - asleep or unpowered, the device neither drives nor loads the shared line.
// - select strapped high gives left channel, strapped low gives right channel.
// - left drives after falling edge, right after rising edge, tristate after half period.
`timescale 1ns/1ns
module pmc_top import pmc_pkg::*; #(
  parameter int START_CYC = PMC_START_CYC,
  parameter int WAKE_CYC = PMC_WAKE_CYC,
  parameter int SLEEP_ENTRY_CYC = PMC_SLEEP_ENTRY_CYC,
  parameter int FIFO_DEPTH = PMC_FIFO_DEPTH
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low active
  input wire logic pdm_clk, // microphone clock from the host
  input wire logic sel_left, // channel select strap, high for left
  input wire logic mod_valid, // modulator bit valid
  output logic mod_ready, // fifo accepts a bit
  input wire logic mod_bit, // modulator output bit
  output logic data_o, // data pin value
  output logic data_oe, // data pin driven
  output logic low_power_listen_mode, // low-power mode active
  output logic std_mode, // standard mode active
  output logic asleep // sleeping, data tristated
);

  typedef struct packed {
    pmc_state_e st;
    logic [PMC_CNT_W-1:0] cnt;
    logic strap_done;
    logic sel_left;
    logic data;
    logic oe;
    logic lp;
    logic std;
  } pmc_top_s;

  pmc_top_s s_q;
  pmc_top_s s_d;

  logic clk_rise;
  logic clk_fall;
  logic clk_slow;
  logic [PMC_PER_W-1:0] clk_period;
  logic fifo_valid;
  logic fifo_pop;
  logic [PMC_FIFO_W-1:0] fifo_data;
  logic drive_edge;
  logic release_edge;
  logic is_lp;

  pmc_clk_mon #(
    .SLEEP_PER(PMC_SLEEP_PER_CYC)
  ) u_mon (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pdm_clk(pdm_clk),
    .rise(clk_rise),
    .fall(clk_fall),
    .slow(clk_slow),
    .period(clk_period)
  );

  // bits queue in the fifo while the line is not running and stall at the modulator once it is full
  pmc_fifo #(
    .W(PMC_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(mod_valid),
    .in_ready(mod_ready),
    .in_data(mod_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // left presents on the falling edge, right on the rising edge
  assign drive_edge = s_q.sel_left ? clk_fall : clk_rise;
  assign release_edge = s_q.sel_left ? clk_rise : clk_fall;
  assign fifo_pop = (s_q.st == PMC_ST_RUN) && !clk_slow && drive_edge && fifo_valid;
  assign is_lp = clk_period >= PMC_PER_W'(PMC_LP_MIN_CYC);

  assign data_o = s_q.data;
  assign data_oe = s_q.oe;
  assign low_power_listen_mode = s_q.lp;
  assign std_mode = s_q.std;
  assign asleep = (s_q.st == PMC_ST_SLEEP);

  always_comb begin
    s_d = s_q;
    // strap sampled once, on the first cycle after reset release
    if (!s_q.strap_done) begin
      s_d.sel_left = sel_left;
      s_d.strap_done = 1'b1;
    end
    case (s_q.st)
      PMC_ST_START: begin
        // start-up count runs only while a clock is present
        if (clk_slow) begin
          s_d.cnt = PMC_CNT_W'(START_CYC);
        end else if (s_q.cnt == '0) begin
          s_d.st = PMC_ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      PMC_ST_SLEEP: begin
        if (!clk_slow) begin
          s_d.st = PMC_ST_WAKE;
          s_d.cnt = PMC_CNT_W'(WAKE_CYC);
        end
      end
      PMC_ST_WAKE: begin
        if (clk_slow) begin
          s_d.st = PMC_ST_SLEEP;
        end else if (s_q.cnt == '0) begin
          s_d.st = PMC_ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      PMC_ST_RUN: begin
        if (clk_slow) begin
          s_d.st = PMC_ST_SLEEP;
        end
      end
      default: begin
        s_d.st = PMC_ST_START;
      end
    endcase

    // data pin: driven for the assigned half period only
    if ((s_q.st != PMC_ST_RUN) || clk_slow) begin
      s_d.oe = 1'b0;
    end else if (drive_edge) begin
      s_d.oe = 1'b1;
      if (fifo_valid) begin
        s_d.data = fifo_data[0];
      end
    end else if (release_edge) begin
      s_d.oe = 1'b0;
    end

    // mode follows the measured clock period while running
    if ((s_q.st == PMC_ST_RUN) && !clk_slow) begin
      s_d.lp = is_lp;
      s_d.std = !is_lp;
    end else begin
      s_d.lp = 1'b0;
      s_d.std = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '{st: PMC_ST_START, cnt: PMC_CNT_W'(START_CYC), strap_done: 1'b0,
               sel_left: PMC_SEL_RST, data: PMC_DATA_RST, oe: 1'b0, lp: 1'b0, std: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // helper counters for the long latency checks
  logic [PMC_CNT_W-1:0] wake_age_q;
  logic [PMC_CNT_W-1:0] slow_age_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_age_q <= '0;
      slow_age_q <= '0;
    end else begin
      if (!clk_slow && (s_q.st != PMC_ST_RUN) && (wake_age_q != '1)) begin
        wake_age_q <= wake_age_q + 1'b1;
      end else if (clk_slow || (s_q.st == PMC_ST_RUN)) begin
        // a lost clock restarts the settling time, so the age restarts with it
        wake_age_q <= '0;
      end
      if (clk_slow && (s_q.st != PMC_ST_SLEEP) && (s_q.st != PMC_ST_START) && (slow_age_q != '1)) begin
        slow_age_q <= slow_age_q + 1'b1;
      end else begin
        slow_age_q <= '0;
      end
    end
  end

  AST_LP_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_RUN) && !clk_slow && is_lp |=> low_power_listen_mode && !std_mode)
    else $error("low-power clock did not select low-power mode");

  AST_SLEEP_HIZ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(clk_slow) |=> !data_oe ##1 (asleep || (s_q.st == PMC_ST_START)))
    else $error("slow clock left data driven or device awake");

  AST_SLEEP_LATENCY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    slow_age_q <= PMC_CNT_W'(SLEEP_ENTRY_CYC))
    else $error("sleep entry took too long");

  AST_WAKE_LATENCY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_WAKE) && !clk_slow && (s_q.cnt == '0) |=> (s_q.st == PMC_ST_RUN))
    else $error("wake-up did not reach run");

  AST_START_LATENCY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_START) |-> wake_age_q <= PMC_CNT_W'(START_CYC) + 1'b1)
    else $error("start-up took too long");

  AST_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st != PMC_ST_RUN) |=> !data_oe)
    else $error("data driven while not running");

  AST_LEFT_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_RUN) && !clk_slow && s_q.sel_left && clk_fall && fifo_valid
      |=> data_oe && (data_o == $past(fifo_data[0])))
    else $error("left channel not driven after falling edge");

  AST_RIGHT_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !s_q.sel_left && clk_fall |=> !data_oe)
    else $error("right channel still driven after falling edge");

  AST_STRAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.strap_done |=> $stable(s_q.sel_left))
    else $error("channel select changed after capture");

  AST_STD_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_RUN) && !clk_slow && !is_lp |=> std_mode && !low_power_listen_mode)
    else $error("standard clock did not select standard mode");

  // mode, latency and line checks that complement the ones above

  AST_MODE_EXCL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(low_power_listen_mode && std_mode))
    else $error("both operating modes active");

  AST_LP_NEEDS_RUN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    low_power_listen_mode |-> ($past(s_q.st) == PMC_ST_RUN))
    else $error("low-power mode reported outside run");

  AST_SLEEP_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep |-> !data_oe && !low_power_listen_mode && !std_mode)
    else $error("sleeping device drives the line or reports a mode");

  AST_SLEEP_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep && clk_slow |=> asleep)
    else $error("device left sleep without a clock");

  AST_SLOW_NO_MODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_slow |=> !low_power_listen_mode && !std_mode)
    else $error("mode reported with a slow clock");

  AST_SLEEP_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((s_q.st == PMC_ST_RUN) || (s_q.st == PMC_ST_WAKE)) && clk_slow |=> asleep)
    else $error("slow clock did not put the device asleep");

  AST_WAKE_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
    asleep && !clk_slow |=> (s_q.st == PMC_ST_WAKE) && (s_q.cnt == PMC_CNT_W'(WAKE_CYC)))
    else $error("returning clock did not start the wake-up count");

  AST_WAKE_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_WAKE) |-> wake_age_q <= PMC_CNT_W'(WAKE_CYC) + 1'b1)
    else $error("wake-up took too long");

  AST_WAKE_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_WAKE) |-> !data_oe)
    else $error("data driven before wake-up settled");

  AST_START_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_START) && clk_slow |=> (s_q.st == PMC_ST_START) && (s_q.cnt == PMC_CNT_W'(START_CYC)))
    else $error("start-up count ran without a clock");

  AST_START_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_START) |-> !data_oe && !low_power_listen_mode && !std_mode)
    else $error("data or mode shown during start-up");

  AST_RUN_FROM_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_RUN) && ($past(s_q.st) == PMC_ST_START) |-> ($past(s_q.cnt) == '0))
    else $error("start-up left before its count ran out");

  AST_SLOW_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_slow |=> !data_oe)
    else $error("data driven with a slow clock");

  AST_STRAP_TAKE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !s_q.strap_done |=> s_q.strap_done && (s_q.sel_left == $past(sel_left)))
    else $error("channel select not captured after reset");

  AST_RIGHT_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_q.st == PMC_ST_RUN) && !clk_slow && !s_q.sel_left && clk_rise && fifo_valid
      |=> data_oe && (data_o == $past(fifo_data[0])))
    else $error("right channel not driven after rising edge");

  AST_LEFT_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_q.sel_left && clk_rise |=> !data_oe)
    else $error("left channel still driven after rising edge");

  AST_STD_NEEDS_RUN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    std_mode |-> ($past(s_q.st) == PMC_ST_RUN))
    else $error("standard mode reported outside run");

  AST_DATA_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !drive_edge |=> $stable(data_o))
    else $error("data changed away from the assigned edge");

endmodule : pmc_top

// *** verification/pmc_host_model.sv ***
// host codec model: makes the microphone clock, samples its channel, decimates
`timescale 1ns/1ns
module pmc_host_model import pmc_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, low active
  input wire logic run, // clock enabled
  input wire logic [9:0] half, // half period in system cycles
  input wire logic sel_left, // channel to decode
  input wire logic data_o, // data pin value
  input wire logic data_oe, // data pin driven
  output logic pdm_clk, // microphone clock
  output logic smp, // sample taken, pulse
  output logic smp_bit, // sampled line level
  output logic smp_oe // line was driven at the sample
);
  logic [9:0] cnt_q;
  logic last_q;
  logic line;
  logic signed [17:0] acc_q;
  // no pull resistor on the line: a released line shows garbage, not the old bit
  assign line = data_oe ? data_o : ~last_q;
  always_ff @(posedge sys_clk) begin
    smp <= 1'b0;
    if (data_oe) last_q <= data_o;
    if (!rst_b || !run) begin
      cnt_q <= 10'h000;
      pdm_clk <= 1'b0;
      acc_q <= 18'sh0;
    // a half period shortened mid-run ends at once instead of wrapping the count
    end else if (cnt_q >= half - 10'h001) begin
      cnt_q <= 10'h000;
      pdm_clk <= ~pdm_clk;
      // sample at the edge that closes the selected half period
      if (pdm_clk != sel_left) begin
        smp <= 1'b1;
        smp_bit <= line;
        smp_oe <= data_oe;
        acc_q <= line ? acc_q + 18'sh1 : acc_q - 18'sh1;
      end
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
endmodule : pmc_host_model

// *** verification/pmc_top_tb.sv ***
// self-checking bench of the microphone clock-mode controller
`timescale 1ns/1ns
module pmc_top_tb;
  import pmc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel_left = 1'b1;
  logic mod_valid = 1'b0;
  logic mod_bit = 1'b0;
  logic run = 1'b0;
  logic [9:0] half = 10'h014;
  logic tog = 1'b1;
  logic rec = 1'b0;
  logic pdm_clk, mod_ready, data_o, data_oe, low_power_listen_mode, std_mode, asleep, smp, smp_bit, smp_oe;
  logic q[$];
  logic [31:0] pat = 32'hc3a5_96f0;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  pmc_top #(.START_CYC(50), .WAKE_CYC(40), .SLEEP_ENTRY_CYC(PMC_SLEEP_ENTRY_CYC), .FIFO_DEPTH(32)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .pdm_clk(pdm_clk), .sel_left(sel_left), .mod_valid(mod_valid),
    .mod_ready(mod_ready), .mod_bit(mod_bit), .data_o(data_o), .data_oe(data_oe),
    .low_power_listen_mode(low_power_listen_mode), .std_mode(std_mode), .asleep(asleep));
  pmc_host_model u_host (.sys_clk(sys_clk), .rst_b(rst_b), .run(run), .half(half), .sel_left(sel_left),
    .data_o(data_o), .data_oe(data_oe), .pdm_clk(pdm_clk), .smp(smp), .smp_bit(smp_bit), .smp_oe(smp_oe));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (tog && mod_valid && mod_ready) mod_bit <= ~mod_bit;
    if (rec && smp && smp_oe) q.push_back(smp_bit);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_int(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("[ERR] %0t got %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_int
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic do_reset(input logic left);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    run <= 1'b0;
    sel_left <= left;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    run <= 1'b1;
  endtask : do_reset
  // data_oe must stay low over n cycles
  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      tick(1);
      if (data_oe !== 1'b0) bad++;
    end
    cmp_int(bad, 0);
  endtask : quiet
  task automatic wait_run(input int lim);
    int i;
    for (i = 0; i < lim && !(std_mode === 1'b1 || low_power_listen_mode === 1'b1); i++) tick(1);
  endtask : wait_run
  // driver must be on only in its own half period
  task automatic chk_phase();
    repeat (4) begin
      @(pdm_clk);
      tick(6);
      cmp_bit(data_oe, pdm_clk ^ sel_left);
    end
  endtask : chk_phase
  task automatic t_start_std();
    do_reset(1'b1);
    mod_valid <= 1'b1;
    quiet(50);
    wait_run(300);
    cmp_bit(std_mode, 1'b1);
    cmp_bit(low_power_listen_mode, 1'b0);
    chk_phase();
    rec = 1'b1;
    tick(200);
    cmp_bit(q[q.size()-1] ^ q[q.size()-2], 1'b1);
    $display("test start_std done");
  endtask : t_start_std
  task automatic t_low_power();
    @(posedge sys_clk) half <= 10'h041;
    tick(600);
    cmp_bit(low_power_listen_mode, 1'b1);
    cmp_bit(std_mode, 1'b0);
    chk_phase();
    $display("test low_power done");
  endtask : t_low_power
  task automatic t_sleep_fill();
    int i;
    int n;
    tog = 1'b0;
    rec = 1'b0;
    @(posedge sys_clk);
    mod_valid <= 1'b0;
    half <= 10'h014;
    tick(1600);
    @(posedge sys_clk) run <= 1'b0;
    for (i = 0; i < 700 && asleep !== 1'b1; i++) tick(1);
    cmp_bit(i < 700, 1'b1);
    cmp_bit(asleep, 1'b1);
    quiet(20);
    n = 0;
    @(posedge sys_clk);
    mod_valid <= 1'b1;
    mod_bit <= pat[0];
    repeat (40) begin
      @(posedge sys_clk);
      if (mod_ready === 1'b1) begin
        n++;
        mod_bit <= pat[n % 32];
      end
    end
    mod_valid <= 1'b0;
    tick(1);
    cmp_int(n, 32);
    cmp_bit(mod_ready, 1'b0);
    $display("test sleep_fill done");
  endtask : t_sleep_fill
  task automatic t_wake();
    int i;
    q.delete();
    rec = 1'b1;
    @(posedge sys_clk) run <= 1'b1;
    quiet(40);
    wait_run(300);
    cmp_bit(asleep, 1'b0);
    cmp_bit(std_mode, 1'b1);
    for (i = 0; i < 2000 && q.size() < 32; i++) tick(1);
    cmp_int(q.size() >= 32, 1);
    for (i = 0; i < 32 && i < q.size(); i++) cmp_bit(q[i], pat[i]);
    $display("test wake done");
  endtask : t_wake
  task automatic t_right();
    tog = 1'b1;
    do_reset(1'b0);
    mod_valid <= 1'b1;
    wait_run(300);
    cmp_bit(std_mode, 1'b1);
    chk_phase();
    $display("test right done");
  endtask : t_right
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  initial begin
    t_start_std();
    t_low_power();
    t_sleep_fill();
    t_wake();
    t_right();
    final_report();
  end
endmodule : pmc_top_tb
